/* File: rtl/switch_lamp_pkg.sv */
// Constants, register map and sequencer states of the switch-to-lamp port logic
//
// Behaviour
// RULE1 - Lamp latch bit 0 drives its pin low, 1 drives it high.
// RULE2 - After reset no pull-up is connected until software enables one.
// RULE3 - A pull-up option bit of 1 connects the pull-up to its input pin.
// RULE4 - Software keeps the upper four lamp pull-up bits at zero.
// RULE5 - A direction bit of 1 makes its pin an input; switch pins 0, 3.
// RULE6 - Software clears any upper switch direction or pull-up bits reset high.
// RULE7 - Software keeps switch pull-up bits 7 and 6 at zero on that variant.
// RULE8 - Initialisation makes all lamp pins outputs and loads latch 00000111.
// RULE9 - Switch port sample is masked down to bits 0 and 3.
// RULE10 - Masked index selects a ten-entry pattern byte written to the lamp latch.
// RULE11 - Only entries 0, 1, 8, 9 are selected; dummy entries never reach pins.
// RULE12 - Index 0, 1, 8, 9 give patterns 03, 05, 06, 07.
// RULE13 - Every pin leaves reset as an input.
// RULE14 - Every output latch leaves reset holding low.
// RULE15 - Sample, mask, lookup and write repeat continuously once running.
package switch_lamp_pkg;

  // Register offsets on the plain register port
  localparam logic [3:0] ADDR_LAMP_LATCH = 4'h0;
  localparam logic [3:0] ADDR_LAMP_DIR   = 4'h1;
  localparam logic [3:0] ADDR_LAMP_PU    = 4'h2;
  localparam logic [3:0] ADDR_SW_VALUE   = 4'h3;
  localparam logic [3:0] ADDR_SW_DIR     = 4'h4;
  localparam logic [3:0] ADDR_SW_PU      = 4'h5;
  localparam logic [3:0] ADDR_CTRL       = 4'h6;
  localparam logic [3:0] ADDR_STATUS     = 4'h7;

  // Control and status field positions
  localparam int CTRL_RUN_BIT   = 0;
  localparam int CTRL_INIT_BIT  = 1;
  localparam int STAT_RUN_BIT   = 0;
  localparam int STAT_SEQ_LSB   = 1;
  localparam int STAT_IDX_LSB   = 4;

  // Reset values
  localparam logic [3:0] LAMP_LATCH_RST = 4'h0;
  localparam logic [3:0] LAMP_DIR_RST   = 4'hF;
  localparam logic [3:0] LAMP_PU_RST    = 4'h0;
  localparam logic [7:0] SW_DIR_RST     = 8'hFF;
  localparam logic [7:0] SW_PU_RST      = 8'h00;

  // Lamp port upper bits: direction reads as ones, latch and pull-up as zeros
  localparam logic [3:0] LAMP_DIR_UPPER = 4'hF;
  localparam logic [3:0] LAMP_ZERO_UPPER = 4'h0;

  // Values loaded by the initialisation step
  localparam logic [7:0] INIT_LAMP_DIR   = 8'hF0;
  localparam logic [7:0] INIT_LAMP_LATCH = 8'h07;
  localparam logic [7:0] INIT_SW_DIR     = 8'h09;
  localparam logic [7:0] INIT_SW_PU      = 8'h09;

  // Switch mask and pattern table
  localparam logic [7:0] SW_MASK     = 8'h09;
  localparam int         TABLE_DEPTH = 10;
  localparam logic [7:0] PAT_IDX0    = 8'h03;
  localparam logic [7:0] PAT_IDX1    = 8'h05;
  localparam logic [7:0] PAT_IDX8    = 8'h06;
  localparam logic [7:0] PAT_IDX9    = 8'h07;
  localparam logic [7:0] PAT_DUMMY   = 8'hFF;

  // Sequencer states
  typedef enum logic [1:0] {
    SEQ_IDLE   = 2'b00,
    SEQ_INIT   = 2'b01,
    SEQ_SAMPLE = 2'b10,
    SEQ_WRITE  = 2'b11
  } seq_state_t;

endpackage

/* File: rtl/lamp_pattern_table.sv */
// Ten-entry lamp pattern table indexed by the masked switch value
`timescale 1ns/1ns
`default_nettype none

module lamp_pattern_table #(
  parameter int DEPTH = switch_lamp_pkg::TABLE_DEPTH
) (
  // Lookup
  input  wire logic [3:0] index,
  output logic      [7:0] pattern
);

  ////////////////////////////////////////////////////////////////////////////
  // Entry contents: four live patterns, the rest dummy
  function automatic logic [7:0] entryValue(input int i);
    logic [7:0] v;
    v = switch_lamp_pkg::PAT_DUMMY;  // see RULE11
    if (i == 0) v = switch_lamp_pkg::PAT_IDX0;  // see RULE12
    if (i == 1) v = switch_lamp_pkg::PAT_IDX1;  // see RULE12
    if (i == 8) v = switch_lamp_pkg::PAT_IDX8;  // see RULE12
    if (i == 9) v = switch_lamp_pkg::PAT_IDX9;  // see RULE12
    return v;
  endfunction

  logic [7:0] lampPatternArray [0:DEPTH-1];

  // Fill the array entry by entry
  for (genvar g = 0; g < DEPTH; g++) begin : gEntry
    assign lampPatternArray[g] = entryValue(g);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Out-of-range index falls back to dummy data
  always_comb begin
    pattern = switch_lamp_pkg::PAT_DUMMY;
    if (int'(index) < DEPTH) begin
      pattern = lampPatternArray[index];  // see RULE10
    end
  end

endmodule

`default_nettype wire

/* File: rtl/switch_to_led_port_logic.sv */
// Switch port sampling, pattern lookup and lamp port drive with register port
//
// The strobed register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none

module switch_to_led_port_logic #(
  parameter logic [7:0] SW_DIR_RESET = switch_lamp_pkg::SW_DIR_RST,
  parameter logic [7:0] SW_PU_RESET  = switch_lamp_pkg::SW_PU_RST
) (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rst,
  // Register port
  input  wire logic [3:0] regAddr,
  input  wire logic [7:0] regWrData,
  input  wire logic       regWrEn,
  input  wire logic       regRdEn,
  output logic      [7:0] regRdData,
  // Switch port pins
  input  wire logic [7:0] switchPinIn,
  output logic      [7:0] switchPullupEn,
  // Lamp port pins
  output logic      [3:0] lampPinOut,
  output logic      [3:0] lampPinOe,
  output logic      [3:0] lampPullupEn,
  // Sequencer state
  output logic            seqRunning
);

  ////////////////////////////////////////////////////////////////////////////
  // State of the block
  typedef struct packed {
    switch_lamp_pkg::seq_state_t seq;
    logic                        run;
    logic [3:0]                  lampLatch;
    logic [3:0]                  lampDir;
    logic [3:0]                  lampPu;
    logic [7:0]                  swDir;
    logic [7:0]                  swPu;
    logic [7:0]                  swValue;
    logic [7:0]                  maskedSwitchIndex;
    logic [3:0]                  lampOe;
    logic [3:0]                  lampPullEn;
    logic [7:0]                  swPullEn;
    logic [7:0]                  rdData;
    logic                        running;
  } state_t;

  state_t     state_ff;
  state_t     nxt_state;
  logic [7:0] tablePattern;
  logic       ctrlWrite;
  logic       initReq;

  ////////////////////////////////////////////////////////////////////////////
  // Pattern table lookup
  lamp_pattern_table #(
    .DEPTH (switch_lamp_pkg::TABLE_DEPTH)
  ) u_lamp_pattern_table (
    .index   (state_ff.maskedSwitchIndex[3:0]),
    .pattern (tablePattern)
  );

  // Control register write decode
  assign ctrlWrite = regWrEn && (regAddr == switch_lamp_pkg::ADDR_CTRL);
  assign initReq   = ctrlWrite && regWrData[switch_lamp_pkg::CTRL_INIT_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Register read multiplexer
  function automatic logic [7:0] readMux(input logic [3:0] a, input state_t s);
    logic [7:0] d;
    d = 8'h00;
    unique case (a)
      switch_lamp_pkg::ADDR_LAMP_LATCH: d = {switch_lamp_pkg::LAMP_ZERO_UPPER, s.lampLatch};
      switch_lamp_pkg::ADDR_LAMP_DIR:   d = {switch_lamp_pkg::LAMP_DIR_UPPER, s.lampDir};
      switch_lamp_pkg::ADDR_LAMP_PU:    d = {switch_lamp_pkg::LAMP_ZERO_UPPER, s.lampPu};
      switch_lamp_pkg::ADDR_SW_VALUE:   d = s.swValue;
      switch_lamp_pkg::ADDR_SW_DIR:     d = s.swDir;
      switch_lamp_pkg::ADDR_SW_PU:      d = s.swPu;
      switch_lamp_pkg::ADDR_CTRL:       d = {7'h00, s.run};
      switch_lamp_pkg::ADDR_STATUS:     d = {s.maskedSwitchIndex[3:0], 1'b0, s.seq, s.running};
      default:                          d = 8'h00;
    endcase
    return d;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    nxt_state = state_ff;

    // Software register writes
    if (regWrEn) begin
      unique case (regAddr)
        switch_lamp_pkg::ADDR_LAMP_LATCH: nxt_state.lampLatch = regWrData[3:0];  // see RULE1
        switch_lamp_pkg::ADDR_LAMP_DIR:   nxt_state.lampDir = regWrData[3:0];
        switch_lamp_pkg::ADDR_LAMP_PU:    nxt_state.lampPu = regWrData[3:0];  // see RULE4
        switch_lamp_pkg::ADDR_SW_DIR:     nxt_state.swDir = regWrData;
        switch_lamp_pkg::ADDR_SW_PU:      nxt_state.swPu = regWrData;  // see RULE7
        switch_lamp_pkg::ADDR_CTRL:       nxt_state.run = regWrData[switch_lamp_pkg::CTRL_RUN_BIT];
        default:                          nxt_state.run = nxt_state.run;
      endcase
    end

    // Sequencer
    unique case (state_ff.seq)
      switch_lamp_pkg::SEQ_IDLE: begin
        if (initReq) begin
          nxt_state.seq = switch_lamp_pkg::SEQ_INIT;
        end else if (state_ff.run) begin
          nxt_state.seq = switch_lamp_pkg::SEQ_SAMPLE;
        end
      end
      switch_lamp_pkg::SEQ_INIT: begin
        // Load the documented port setup
        nxt_state.lampDir   = switch_lamp_pkg::INIT_LAMP_DIR[3:0];    // see RULE8
        nxt_state.lampLatch = switch_lamp_pkg::INIT_LAMP_LATCH[3:0];  // see RULE8
        nxt_state.swDir     = switch_lamp_pkg::INIT_SW_DIR;           // see RULE5
        nxt_state.swPu      = switch_lamp_pkg::INIT_SW_PU;            // see RULE3
        nxt_state.seq       = nxt_state.run ? switch_lamp_pkg::SEQ_SAMPLE
                                            : switch_lamp_pkg::SEQ_IDLE;
      end
      switch_lamp_pkg::SEQ_SAMPLE: begin
        // Keep only the two switch bits
        nxt_state.maskedSwitchIndex = switchPinIn & state_ff.swDir
                                      & switch_lamp_pkg::SW_MASK;  // see RULE9
        nxt_state.seq = switch_lamp_pkg::SEQ_WRITE;
        if (initReq) begin
          nxt_state.seq = switch_lamp_pkg::SEQ_INIT;
        end
      end
      switch_lamp_pkg::SEQ_WRITE: begin
        // Loop write wins over a software latch write in the same cycle
        nxt_state.lampLatch = tablePattern[3:0];  // see RULE10
        if (initReq) begin
          nxt_state.seq = switch_lamp_pkg::SEQ_INIT;
        end else if (nxt_state.run) begin
          nxt_state.seq = switch_lamp_pkg::SEQ_SAMPLE;  // see RULE15
        end else begin
          nxt_state.seq = switch_lamp_pkg::SEQ_IDLE;
        end
      end
    endcase

    // Port value as seen by software: input-mode pins only
    nxt_state.swValue = switchPinIn & state_ff.swDir;  // see RULE5

    // Pin drivers derived from the next register values
    nxt_state.lampOe     = ~nxt_state.lampDir;                     // see RULE13
    nxt_state.lampPullEn = nxt_state.lampPu & nxt_state.lampDir;   // see RULE3
    nxt_state.swPullEn   = nxt_state.swPu & nxt_state.swDir;       // see RULE3
    nxt_state.running    = (nxt_state.seq == switch_lamp_pkg::SEQ_SAMPLE)
                           || (nxt_state.seq == switch_lamp_pkg::SEQ_WRITE);

    // Read data stands for one cycle only
    nxt_state.rdData = regRdEn ? readMux(regAddr, state_ff) : 8'h00;

    // Synchronous reset
    if (rst) begin
      nxt_state.seq               = switch_lamp_pkg::SEQ_IDLE;
      nxt_state.run               = 1'b0;
      nxt_state.lampLatch         = switch_lamp_pkg::LAMP_LATCH_RST;  // see RULE14
      nxt_state.lampDir           = switch_lamp_pkg::LAMP_DIR_RST;    // see RULE13
      nxt_state.lampPu            = switch_lamp_pkg::LAMP_PU_RST;     // see RULE2
      nxt_state.swDir             = SW_DIR_RESET;                     // see RULE6
      nxt_state.swPu              = SW_PU_RESET;                      // see RULE2
      nxt_state.swValue           = 8'h00;
      nxt_state.maskedSwitchIndex = 8'h00;
      nxt_state.lampOe            = 4'h0;
      nxt_state.lampPullEn        = 4'h0;
      nxt_state.swPullEn          = 8'h00;
      nxt_state.rdData            = 8'h00;
      nxt_state.running           = 1'b0;
    end
  end

  // State register
  always_ff @(posedge clock) begin
    state_ff <= nxt_state;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs straight from the state register
  assign regRdData      = state_ff.rdData;
  assign switchPullupEn = state_ff.swPullEn;
  assign lampPinOut     = state_ff.lampLatch;
  assign lampPinOe      = state_ff.lampOe;
  assign lampPullupEn   = state_ff.lampPullEn;
  assign seqRunning     = state_ff.running;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cbMain @(posedge clock);
  endclocking
  default disable iff (rst);

  // Expected lamp nibble for a live index
  function automatic logic [3:0] expectedLamp(input logic [7:0] idx);
    logic [3:0] e;
    e = switch_lamp_pkg::PAT_DUMMY[3:0];
    if (idx == 8'h00) e = switch_lamp_pkg::PAT_IDX0[3:0];
    if (idx == 8'h01) e = switch_lamp_pkg::PAT_IDX1[3:0];
    if (idx == 8'h08) e = switch_lamp_pkg::PAT_IDX8[3:0];
    if (idx == 8'h09) e = switch_lamp_pkg::PAT_IDX9[3:0];
    return e;
  endfunction

  // Sample, write and initialisation step sequences
  sequence seqSampleStep;
    state_ff.seq == switch_lamp_pkg::SEQ_SAMPLE;
  endsequence

  sequence seqWriteStep;
    state_ff.seq == switch_lamp_pkg::SEQ_WRITE;
  endsequence

  sequence seqInitStep;
    state_ff.seq == switch_lamp_pkg::SEQ_INIT;
  endsequence

  AST_RESET_INPUTS: assert property ($past(rst) |-> lampPinOe == 4'h0)  // see RULE13
    else $error("lamp pin driven right after reset");

  AST_RESET_LATCH_LOW: assert property ($past(rst) |-> lampPinOut == 4'h0)  // see RULE14
    else $error("lamp latch not low right after reset");

  AST_RESET_NO_PULLUP: assert property (  // see RULE2
    $past(rst) |-> (switchPullupEn == 8'h00) && (lampPullupEn == 4'h0))
    else $error("pull-up connected right after reset");

  AST_PULLUP_CONNECT: assert property (  // see RULE3
    regWrEn && regAddr == switch_lamp_pkg::ADDR_SW_PU
    && state_ff.seq != switch_lamp_pkg::SEQ_INIT
    |=> switchPullupEn == ($past(regWrData) & state_ff.swDir))
    else $error("switch pull-up enable does not follow option write");

  AST_LATCH_LEVEL: assert property (  // see RULE1
    regWrEn && regAddr == switch_lamp_pkg::ADDR_LAMP_LATCH
    && state_ff.seq == switch_lamp_pkg::SEQ_IDLE && !initReq
    |=> lampPinOut == $past(regWrData[3:0]))
    else $error("lamp pin level does not follow latch write");

  AST_INIT_LOAD: assert property (  // see RULE8
    state_ff.seq == switch_lamp_pkg::SEQ_INIT
    |=> lampPinOe == 4'hF && lampPinOut == 4'h7 && state_ff.swDir == 8'h09)
    else $error("initialisation did not load port setup");

  AST_MASKED_SAMPLE: assert property (  // see RULE5
    seqSampleStep |=> state_ff.maskedSwitchIndex
                      == ($past(switchPinIn) & $past(state_ff.swDir) & 8'h09))
    else $error("sampled index does not match input pins");

  AST_MASK_BITS: assert property ((state_ff.maskedSwitchIndex & 8'hF6) == 8'h00)  // see RULE9
    else $error("masked index holds bits other than 0 and 3");

  AST_LOOKUP_WRITE: assert property (  // see RULE12
    seqSampleStep ##1 seqWriteStep
    |=> lampPinOut == expectedLamp($past(state_ff.maskedSwitchIndex)))
    else $error("lamp pattern does not match switch index");

  AST_NO_DUMMY: assert property (  // see RULE11
    seqWriteStep |-> state_ff.maskedSwitchIndex inside {8'h00, 8'h01, 8'h08, 8'h09})
    else $error("dummy table entry selected");

  AST_LOOP_REPEATS: assert property (  // see RULE15
    (seqWriteStep and (state_ff.run && !ctrlWrite))
    |=> seqSampleStep ##1 (seqWriteStep or seqInitStep))
    else $error("sample-lookup loop stopped while running");

  AST_LAMP_PU_UPPER: assert property (  // see RULE4
    regRdEn && regAddr == switch_lamp_pkg::ADDR_LAMP_PU |=> regRdData[7:4] == 4'h0)
    else $error("lamp pull-up upper bits read non-zero");

  // Pull-ups never sit on a driven lamp pin
  AST_LAMP_PU_INPUT_ONLY: assert property ((lampPullupEn & lampPinOe) == 4'h0)  // see RULE5
    else $error("lamp pull-up enabled on an output pin");

  // Initialisation leaves both switch pins pulled up
  AST_INIT_PULLUP: assert property (  // see RULE3
    seqInitStep |=> switchPullupEn == 8'h09)
    else $error("switch pull-ups not connected after initialisation");

  // Lamp direction write sets the pin drivers
  AST_LAMP_DIR_DRIVE: assert property (  // see RULE5
    regWrEn && regAddr == switch_lamp_pkg::ADDR_LAMP_DIR
    && state_ff.seq != switch_lamp_pkg::SEQ_INIT
    |=> lampPinOe == ~$past(regWrData[3:0]))
    else $error("lamp pin drivers do not follow direction write");

  // A sample step is followed by its write step unless software restarts
  AST_SAMPLE_THEN_WRITE: assert property (  // see RULE15
    seqSampleStep |=> seqWriteStep or seqInitStep)
    else $error("sample step not followed by write step");

  // The write step never raises the spare lamp pin
  AST_SPARE_PIN_LOW: assert property (  // see RULE11
    seqWriteStep |=> lampPinOut[3] == 1'b0)
    else $error("spare lamp pin raised by the write step");

  // Sequencer flag follows the loop states
  AST_RUNNING_FLAG: assert property (  // see RULE15
    seqRunning == (state_ff.seq inside {switch_lamp_pkg::SEQ_SAMPLE,
                                        switch_lamp_pkg::SEQ_WRITE}))
    else $error("running flag does not match sequencer state");

  // Switch direction write lands unless initialisation overrides it
  AST_SW_DIR_WRITE: assert property (  // see RULE5
    regWrEn && regAddr == switch_lamp_pkg::ADDR_SW_DIR
    && state_ff.seq != switch_lamp_pkg::SEQ_INIT
    |=> state_ff.swDir == $past(regWrData))
    else $error("switch direction write did not land");

endmodule

`default_nettype wire

/* File: test/switch_lamp_partner.sv */
// Behavioural push switches and indicator lamps on the block's port pins
`timescale 1ns/1ns
`default_nettype none

module switch_lamp_partner (
  // Clock
  input  wire logic       clock,
  // Switch control from the bench
  input  wire logic       swOnePressed,
  input  wire logic       swTwoPressed,
  input  wire logic [7:0] otherPins,
  // Switch port pins
  input  wire logic [7:0] switchPullupEn,
  output logic      [7:0] switchPinIn,
  // Lamp port pins
  input  wire logic [3:0] lampPinOut,
  input  wire logic [3:0] lampPinOe,
  output logic      [2:0] lampLit
);
  logic floatToggle;

  ////////////////////////////////////////////////////////////////////////////////
  // An open pin with no pull-up wanders, so it never reads as a steady level
  initial floatToggle = 1'b0;
  always @(posedge clock) begin
    floatToggle <= ~floatToggle;
  end

  // A pressed switch grounds its pin; released, only the pull-up holds it high
  always_comb begin
    switchPinIn = otherPins;
    switchPinIn[0] = swOnePressed ? 1'b0 : (switchPullupEn[0] ? 1'b1 : floatToggle);
    switchPinIn[3] = swTwoPressed ? 1'b0 : (switchPullupEn[3] ? 1'b1 : floatToggle);
  end

  // A lamp lights only when its pin is driven low
  assign lampLit = lampPinOe[2:0] & ~lampPinOut[2:0];
endmodule
`default_nettype wire

/* File: test/switch_to_led_port_logic_tb.sv */
// Self-checking bench for the switch-to-lamp port logic
`timescale 1ns/1ns
`default_nettype none

module switch_to_led_port_logic_tb;
  logic       clock;
  logic       rst;
  logic [3:0] regAddr;
  logic [7:0] regWrData;
  logic       regWrEn;
  logic       regRdEn;
  logic [7:0] regRdData;
  logic [7:0] switchPinIn;
  logic [7:0] switchPullupEn;
  logic [3:0] lampPinOut;
  logic [3:0] lampPinOe;
  logic [3:0] lampPullupEn;
  logic       seqRunning;
  logic       swOnePressed;
  logic       swTwoPressed;
  logic [7:0] otherPins;
  logic [2:0] lampLit;
  int         failCount;
  int         checked;

  switch_to_led_port_logic u_switch_to_led_port_logic (
    .clock(clock), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
    .switchPinIn(switchPinIn), .switchPullupEn(switchPullupEn), .lampPinOut(lampPinOut),
    .lampPinOe(lampPinOe), .lampPullupEn(lampPullupEn), .seqRunning(seqRunning));

  switch_lamp_partner u_switch_lamp_partner (
    .clock(clock), .swOnePressed(swOnePressed), .swTwoPressed(swTwoPressed),
    .otherPins(otherPins), .switchPullupEn(switchPullupEn), .switchPinIn(switchPinIn),
    .lampPinOut(lampPinOut), .lampPinOe(lampPinOe), .lampLit(lampLit));

  ////////////////////////////////////////////////////////////////////////////////
  // Clock generation
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // Comparison and closing helpers
  task automatic check8(input string name, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", name, exp, got);
      failCount++;
    end
  endtask

  task automatic reportAndStop();
    $display("comparisons %0d mismatches %0d", checked, failCount);
    if (failCount == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Register port cycles
  task automatic regWrite(input logic [3:0] addr, input logic [7:0] data);
    @(posedge clock);
    regAddr <= addr;
    regWrData <= data;
    regWrEn <= 1'b1;
    @(posedge clock);
    regWrEn <= 1'b0;
    #1;
  endtask

  task automatic regRead(input logic [3:0] addr, input logic [7:0] exp, input string name);
    @(posedge clock);
    regAddr <= addr;
    regRdEn <= 1'b1;
    @(posedge clock);
    regRdEn <= 1'b0;
    #1;
    check8(name, exp, regRdData);
  endtask

  task automatic waitRunning(input logic level);
    for (int n = 0; n < 20 && seqRunning !== level; n++) begin
      @(posedge clock);
      #1;
    end
    if (seqRunning !== level) begin
      $display("mismatch seqRunning expected %b seen %b", level, seqRunning);
      failCount++;
      reportAndStop();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic testReset();
    check8("lampPinOe", 8'h00, {4'h0, lampPinOe});
    check8("lampPinOut", 8'h00, {4'h0, lampPinOut});
    check8("switchPullupEn", 8'h00, switchPullupEn);
    check8("lampPullupEn", 8'h00, {4'h0, lampPullupEn});
    regRead(switch_lamp_pkg::ADDR_LAMP_LATCH, 8'h00, "lampLatch");
    regRead(switch_lamp_pkg::ADDR_LAMP_DIR, 8'hFF, "lampDir");
    regRead(switch_lamp_pkg::ADDR_SW_DIR, 8'hFF, "swDir");
    regRead(switch_lamp_pkg::ADDR_SW_PU, 8'h00, "swPu");
    regRead(switch_lamp_pkg::ADDR_LAMP_PU, 8'h00, "lampPu");
    regRead(4'h8, 8'h00, "unmapped");
    $display("test reset done");
  endtask

  task automatic testDirect();
    regWrite(switch_lamp_pkg::ADDR_SW_PU, 8'h09);
    check8("switchPullupEn", 8'h09, switchPullupEn);
    regWrite(switch_lamp_pkg::ADDR_SW_DIR, 8'h01);
    check8("switchPullupEn", 8'h01, switchPullupEn);
    regWrite(switch_lamp_pkg::ADDR_LAMP_PU, 8'h0F);
    check8("lampPullupEn", 8'h0F, {4'h0, lampPullupEn});
    regWrite(switch_lamp_pkg::ADDR_LAMP_DIR, 8'hF0);
    check8("lampPinOe", 8'h0F, {4'h0, lampPinOe});
    check8("lampPullupEn", 8'h00, {4'h0, lampPullupEn});
    regWrite(switch_lamp_pkg::ADDR_LAMP_LATCH, 8'h05);
    check8("lampPinOut", 8'h05, {4'h0, lampPinOut});
    check8("lampLit", 8'h02, {5'h00, lampLit});
    regWrite(switch_lamp_pkg::ADDR_LAMP_LATCH, 8'h0A);
    check8("lampPinOut", 8'h0A, {4'h0, lampPinOut});
    regWrite(switch_lamp_pkg::ADDR_LAMP_PU, 8'h00);
    $display("test direct done");
  endtask

  task automatic testRun();
    logic [3:0] pat [4];
    logic       press1 [4];
    logic       press2 [4];
    int         i;
    pat = '{switch_lamp_pkg::PAT_IDX0[3:0], switch_lamp_pkg::PAT_IDX1[3:0],
            switch_lamp_pkg::PAT_IDX8[3:0], switch_lamp_pkg::PAT_IDX9[3:0]};
    press1 = '{1'b1, 1'b0, 1'b1, 1'b0};
    press2 = '{1'b1, 1'b1, 1'b0, 1'b0};
    regWrite(switch_lamp_pkg::ADDR_CTRL, 8'h03);
    waitRunning(1'b1);
    check8("lampPinOe", 8'h0F, {4'h0, lampPinOe});
    check8("switchPullupEn", 8'h09, switchPullupEn);
    regRead(switch_lamp_pkg::ADDR_LAMP_DIR, 8'hF0, "lampDir");
    regRead(switch_lamp_pkg::ADDR_SW_DIR, 8'h09, "swDir");
    regRead(switch_lamp_pkg::ADDR_CTRL, 8'h01, "ctrlRun");
    for (int k = 0; k < 8; k++) begin
      i = (k * 3) % 4;
      @(posedge clock);
      swOnePressed <= press1[i];
      swTwoPressed <= press2[i];
      otherPins <= k[0] ? 8'hF6 : 8'h00;
      #1;
      for (int n = 0; n < 8 && lampPinOut !== pat[i]; n++) begin
        @(posedge clock);
        #1;
        check8("lampPin3", 8'h00, {7'h00, lampPinOut[3]});
      end
      check8("lampPinOut", {4'h0, pat[i]}, {4'h0, lampPinOut});
      if (lampPinOut !== pat[i]) reportAndStop();
      check8("lampLit", {5'h00, ~pat[i][2:0]}, {5'h00, lampLit});
      regRead(switch_lamp_pkg::ADDR_SW_VALUE, {4'h0, ~press2[i], 2'b00, ~press1[i]},
              "switchValue");
    end
    $display("test run done");
  endtask

  task automatic testStop();
    regWrite(switch_lamp_pkg::ADDR_CTRL, 8'h00);
    waitRunning(1'b0);
    regWrite(switch_lamp_pkg::ADDR_LAMP_LATCH, 8'h02);
    repeat (4) @(posedge clock);
    #1;
    check8("lampPinOut", 8'h02, {4'h0, lampPinOut});
    regRead(switch_lamp_pkg::ADDR_LAMP_LATCH, 8'h02, "lampLatch");
    regRead(switch_lamp_pkg::ADDR_STATUS, 8'h10, "status");
    $display("test stop done");
  endtask

  // Main sequence
  initial begin
    failCount = 0;
    checked = 0;
    rst = 1'b1;
    regAddr = 4'h0;
    regWrData = 8'h00;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    swOnePressed = 1'b0;
    swTwoPressed = 1'b0;
    otherPins = 8'h00;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    #1;
    testReset();
    testDirect();
    testRun();
    testStop();
    reportAndStop();
  end
endmodule
`default_nettype wire
